// ---- shared/timer16_pkg.sv ----
// Purpose: shared constants of the byte-wide 16-bit timer and its cpu end
// Assumes: byte addresses on a 4-bit address bus
// Notes: wide registers sit at even (low byte) / odd (high byte) pairs
package timer16_pkg;
	localparam logic [3:0] ADDR_CNT_LO = 4'h0;
	localparam logic [3:0] ADDR_CNT_HI = 4'h1;
	localparam logic [3:0] ADDR_CMPA_LO = 4'h2;
	localparam logic [3:0] ADDR_CMPB_LO = 4'h4;
	localparam logic [3:0] ADDR_CMPC_LO = 4'h6;
	localparam logic [3:0] ADDR_CAP_LO = 4'h8;
	localparam logic [3:0] ADDR_WIDE_END = 4'ha;
	localparam logic [3:0] ADDR_CTRL_A = 4'ha;
	localparam logic [3:0] ADDR_CTRL_B = 4'hb;
	localparam logic [3:0] ADDR_FLAGS = 4'hc;
	localparam logic [3:0] ADDR_MASK = 4'hd;
	localparam logic [2:0] IDX_CNT = 3'h0;
	localparam logic [2:0] IDX_CAP = 3'h4;
	localparam int CTRL_A_WGM_LSB = 0;
	localparam int CTRL_B_WGM_LSB = 3;
	localparam int CTRL_B_CS_LSB = 0;
	localparam int FLAG_OVF_BIT = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] WIDE_RESET = 16'h0000;
	localparam logic [15:0] TOP_FIX8 = 16'h00ff;
	localparam logic [15:0] TOP_FIX9 = 16'h01ff;
	localparam logic [15:0] TOP_FIX10 = 16'h03ff;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam int PRESC_W = 10;
endpackage

// ---- shared/timer_bus_if.sv ----
// Purpose: 8-bit data bus between cpu end and timer end
// Assumes: one clock; read data valid the cycle after rd_en
// Notes: irq is a level, int_ack a one-cycle pulse
`timescale 1ns/100ps
interface timer_bus_if;
	logic [3:0] addr;
	logic wr_en;
	logic rd_en;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic irq;
	logic int_ack;
	modport dev (input addr, input wr_en, input rd_en, input wdata, input int_ack,
		output rdata, output irq);
	modport cpu (output addr, output wr_en, output rd_en, output wdata, output int_ack,
		input rdata, input irq);
endinterface

// ---- tb/timer16_sva.sv ----
// Purpose: bus-level checks between cpu end and timer end
// Assumes: one clock domain, shadows track only what the bus shows
// Notes: shadows go invalid whenever the counter may move
`timescale 1ns/100ps
module timer16_sva (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [3:0] addr,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic irq
);
	logic [7:0] hold_q;
	logic hold_ok;
	logic [15:0] cnt_q;
	logic cnt_ok;
	logic [2:0] cs_q;
	logic mask_q;
	logic [15:0] cmp_q [1:3];
	logic [3:1] cmp_ok;
	logic [15:0] cmp_sel;
	logic sel_ok;
	logic is_cmp;
	assign is_cmp = addr >= 4'h2 && addr < 4'h8;
	always_comb begin
		cmp_sel = is_cmp ? cmp_q[addr[2:1]] : 16'h0000;
		sel_ok = is_cmp ? cmp_ok[addr[2:1]] : 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hold_q <= 8'h00;
			hold_ok <= 1'b0;
			cnt_q <= 16'h0000;
			cnt_ok <= 1'b1;
			cs_q <= 3'h0;
			mask_q <= 1'b0;
			cmp_q <= '{16'h0000, 16'h0000, 16'h0000};
			cmp_ok <= 3'h0;
		end else begin
			if (wr_en && addr < timer16_pkg::ADDR_WIDE_END && addr[0]) begin
				hold_q <= wdata;
				hold_ok <= 1'b1;
			end
			if (wr_en && is_cmp && !addr[0] && hold_ok) begin
				cmp_q[addr[2:1]] <= {hold_q, wdata};
				cmp_ok[addr[2:1]] <= 1'b1;
			end
			if (wr_en && addr == timer16_pkg::ADDR_CNT_LO) begin
				cnt_q <= {hold_q, wdata};
				cnt_ok <= hold_ok && cs_q == timer16_pkg::CS_STOP;
			end
			if (wr_en && addr == timer16_pkg::ADDR_CTRL_B) begin
				cs_q <= wdata[2:0];
				if (wdata[2:0] != timer16_pkg::CS_STOP) begin
					cnt_ok <= 1'b0;
				end
			end
			if (rd_en && addr == timer16_pkg::ADDR_CNT_LO) begin
				hold_q <= cnt_q[15:8];
				hold_ok <= cnt_ok && cs_q == timer16_pkg::CS_STOP;
			end
			if (rd_en && addr == timer16_pkg::ADDR_CAP_LO) begin
				hold_ok <= 1'b0;
			end
			if (wr_en && addr == timer16_pkg::ADDR_MASK) begin
				mask_q <= wdata[0];
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	a_no_dual_strobe: assert property (!(wr_en && rd_en))
		else $error("read and write strobes together");
	a_rdata_holds: assert property (!rd_en |=> $stable(rdata))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (rd_en && addr >= 4'he |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_hold_high_read: assert property (rd_en && hold_ok && (addr == 4'h1 || addr == 4'h9)
		|=> rdata == $past(hold_q)) else $error("high read not from holding");
	a_cmp_low_value: assert property (rd_en && sel_ok && !addr[0]
		|=> rdata == $past(cmp_sel[7:0])) else $error("compare low wrong");
	a_cmp_high_bypass: assert property (rd_en && sel_ok && addr[0]
		|=> rdata == $past(cmp_sel[15:8])) else $error("compare high wrong");
	a_stopped_count_low: assert property (rd_en && cnt_ok && addr == 4'h0
		&& cs_q == 3'h0 |=> rdata == $past(cnt_q[7:0])) else $error("stopped counter low wrong");
	a_irq_masked: assert property (!mask_q && !$past(mask_q) |-> !irq)
		else $error("interrupt while masked");
endmodule

// ---- tb/wide_counter_byte_access_tb.sv ----
// Purpose: drives the cpu end against the timer end and checks results
// Assumes: commands issued one at a time through the cpu command port
// Notes: external pin toggles every five clocks for the pin clock codes
`timescale 1ns/100ps
module wide_counter_byte_access_tb;
	logic clk, nrst, ext_clk_pin, service_pulse;
	logic cmd_valid, cmd_write, cmd_wide, cmd_ready, resp_valid, irq_level;
	logic [3:0] cmd_addr;
	logic [15:0] cmd_wdata, resp_data, r;
	logic at_top, at_bottom, count_down, tick_seen;
	int failures = 0;
	int tests_run = 0;
	int n;
	timer_bus_if timer_bus_if_i ();
	timer16_device timer16_device_i (.clk(clk), .nrst(nrst), .bus(timer_bus_if_i.dev),
		.ext_clk_pin(ext_clk_pin), .at_top(at_top), .at_bottom(at_bottom),
		.count_down(count_down), .tick_seen(tick_seen));
	timer16_cpu timer16_cpu_i (.clk(clk), .nrst(nrst), .bus(timer_bus_if_i.cpu),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_wide(cmd_wide),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
		.resp_valid(resp_valid), .resp_data(resp_data), .service_pulse(service_pulse),
		.irq_level(irq_level));
	timer16_sva timer16_sva_i (.clk(clk), .nrst(nrst), .addr(timer_bus_if_i.addr),
		.wr_en(timer_bus_if_i.wr_en), .rd_en(timer_bus_if_i.rd_en),
		.wdata(timer_bus_if_i.wdata), .rdata(timer_bus_if_i.rdata), .irq(timer_bus_if_i.irq));
	always #2 clk = ~clk;
	always begin
		repeat (5) @(posedge clk);
		#1 ext_clk_pin = ~ext_clk_pin;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic w, input logic wd, input logic [3:0] a, input logic [15:0] d);
		int k;
		@(posedge clk);
		#1 {cmd_valid, cmd_write, cmd_wide, cmd_addr, cmd_wdata} = {1'b1, w, wd, a, d};
		@(posedge clk);
		#1 cmd_valid = 1'b0;
		k = 0;
		while (cmd_ready !== 1'b1 && k < 50) begin
			@(posedge clk);
			#1 k++;
		end
		limit_hit(k, 50);
		chk(16'(resp_valid), 16'h0001);
		r = resp_data;
	endtask
	task automatic limit_hit(input int k, input int lim);
		if (k >= lim) begin
			failures++;
			tally_and_finish();
		end
	endtask
	task automatic wait_irq(input logic v);
		n = 0;
		while (irq_level !== v && n < 100) begin
			@(posedge clk);
			#1 n++;
		end
		limit_hit(n, 100);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic s_wide_count();
		cmd(1, 1, 4'h0, 16'h01ff);
		cmd(0, 1, 4'h0, 16'h0000);
		chk(r, 16'h01ff);
		cmd(0, 0, 4'h1, 16'h0000);
		chk(r, 16'h0001);
	endtask
	task automatic s_shared_hold();
		cmd(1, 0, 4'h3, 16'h005a);
		for (int i = 0; i < 3; i++) cmd(1, 0, 4'(2 + 2 * i), 16'(8'h10 + i));
		for (int i = 0; i < 3; i++) begin
			cmd(0, 1, 4'(2 + 2 * i), 16'h0000);
			chk(r, {8'h5a, 8'(8'h10 + i)});
		end
		cmd(0, 0, 4'h1, 16'h0000);
		chk(r, 16'h005a);
	endtask
	task automatic s_clock_sel();
		for (int c = 0; c < 8; c++) begin
			cmd(1, 1, 4'h0, 16'h0000);
			cmd(1, 0, timer16_pkg::ADDR_CTRL_B, 16'(c));
			repeat (2100) @(posedge clk);
			#1;
			if (c < 2) chk(16'(tick_seen), 16'(c));
			cmd(1, 0, timer16_pkg::ADDR_CTRL_B, 16'h0000);
			repeat (8) @(posedge clk);
			cmd(0, 1, 4'h0, 16'h0000);
			chk(16'(r != 16'h0000), 16'(c != 0));
		end
	endtask
	task automatic s_overflow();
		cmd(1, 0, timer16_pkg::ADDR_MASK, 16'h0001);
		cmd(1, 1, 4'h0, 16'hfff0);
		cmd(1, 0, timer16_pkg::ADDR_CTRL_B, 16'h0001);
		wait_irq(1'b1);
		chk(16'(irq_level), 16'h0001);
		cmd(1, 0, timer16_pkg::ADDR_CTRL_B, 16'h0000);
		@(posedge clk);
		#1 service_pulse = 1'b1;
		@(posedge clk);
		#1 service_pulse = 1'b0;
		wait_irq(1'b0);
		chk(16'(irq_level), 16'h0000);
		cmd(1, 0, timer16_pkg::ADDR_MASK, 16'h0000);
		cmd(1, 1, 4'h0, 16'hfff0);
		cmd(1, 0, timer16_pkg::ADDR_CTRL_B, 16'h0001);
		repeat (60) @(posedge clk);
		cmd(1, 1, 4'h0, 16'h0100);
		cmd(1, 0, timer16_pkg::ADDR_CTRL_B, 16'h0000);
		cmd(0, 1, 4'h0, 16'h0000);
		chk(16'(r >= 16'h0100 && r < 16'h0110), 16'h0001);
		cmd(0, 0, timer16_pkg::ADDR_FLAGS, 16'h0000);
		chk(r, 16'h0001);
		cmd(1, 0, timer16_pkg::ADDR_FLAGS, 16'h0001);
		cmd(0, 0, timer16_pkg::ADDR_FLAGS, 16'h0000);
		chk(r, 16'h0000);
	endtask
	task automatic s_capture();
		cmd(1, 1, timer16_pkg::ADDR_CAP_LO, 16'h1111);
		cmd(0, 1, timer16_pkg::ADDR_CAP_LO, 16'h0000);
		chk(r, 16'h0000);
		cmd(1, 0, timer16_pkg::ADDR_CTRL_A, 16'h0002);
		cmd(1, 0, timer16_pkg::ADDR_CTRL_B, 16'h0018);
		cmd(1, 1, timer16_pkg::ADDR_CAP_LO, 16'h2222);
		cmd(0, 1, timer16_pkg::ADDR_CAP_LO, 16'h0000);
		chk(r, 16'h2222);
		cmd(0, 0, 4'he, 16'h0000);
		chk(r, 16'h0000);
	endtask
	task automatic s_dual();
		cmd(1, 0, timer16_pkg::ADDR_CTRL_A, 16'h0001);
		cmd(1, 1, 4'h0, 16'h00f0);
		cmd(1, 0, timer16_pkg::ADDR_CTRL_B, 16'h0001);
		n = 0;
		while (at_top !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1 n++;
		end
		limit_hit(n, 100);
		chk(16'(at_top), 16'h0001);
		n = 0;
		while (count_down !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		limit_hit(n, 20);
		chk(16'(count_down), 16'h0001);
		n = 0;
		while (at_bottom !== 1'b1 && n < 600) begin
			@(posedge clk);
			#1 n++;
		end
		limit_hit(n, 600);
		chk(16'(at_bottom), 16'h0001);
		chk(16'(count_down), 16'h0001);
		cmd(1, 0, timer16_pkg::ADDR_CTRL_B, 16'h0000);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{clk, nrst, ext_clk_pin, service_pulse} = 4'h0;
		{cmd_valid, cmd_write, cmd_wide, cmd_addr, cmd_wdata} = '0;
		repeat (20) @(posedge clk);
		#1 nrst = 1'b1;
		chk(16'(at_bottom), 16'h0001);
		s_wide_count();
		s_shared_hold();
		s_clock_sel();
		s_overflow();
		s_capture();
		s_dual();
		tally_and_finish();
	end
endmodule

// ---- verilog/timer16_cpu.sv ----
// Purpose: cpu end issuing byte and wide accesses to the timer
// Assumes: user holds a command until cmd_ready is seen with cmd_valid
// Notes: wide writes go high then low, wide reads low then high
`timescale 1ns/100ps
module timer16_cpu (
	input wire logic clk,
	input wire logic nrst,
	timer_bus_if.cpu bus,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic cmd_wide,
	input wire logic [3:0] cmd_addr,
	input wire logic [15:0] cmd_wdata,
	output logic cmd_ready,
	output logic resp_valid,
	output logic [15:0] resp_data,
	input wire logic service_pulse,
	output logic irq_level
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SECOND = 2'b01,
		ST_COLLECT = 2'b10,
		ST_LAST = 2'b11
	} state_t;

	state_t state_q;
	logic [3:0] addr_q;
	logic wr_q;
	logic rd_q;
	logic [7:0] wdata_q;
	logic [7:0] hold_q;
	logic is_read_q;
	logic wide_q;
	logic ready_q;
	logic resp_valid_q;
	logic [15:0] resp_q;
	logic ack_q;
	logic irq_q;

	////////////////////////////////////////////////////////////////////////////////
	// access sequencer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			addr_q <= 4'h0;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			wdata_q <= 8'h00;
			hold_q <= 8'h00;
			is_read_q <= 1'b0;
			wide_q <= 1'b0;
			ready_q <= 1'b1;
			resp_valid_q <= 1'b0;
			resp_q <= 16'h0000;
		end else begin
			resp_valid_q <= 1'b0;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (cmd_valid && ready_q) begin
						ready_q <= 1'b0;
						is_read_q <= !cmd_write;
						wide_q <= cmd_wide;
						wr_q <= cmd_write;
						rd_q <= !cmd_write;
						if (cmd_wide && cmd_write) begin
							addr_q <= {cmd_addr[3:1], 1'b1};
							wdata_q <= cmd_wdata[15:8];
							hold_q <= cmd_wdata[7:0];
						end else begin
							addr_q <= cmd_wide ? {cmd_addr[3:1], 1'b0} : cmd_addr;
							wdata_q <= cmd_wdata[7:0];
						end
						state_q <= cmd_wide ? ST_SECOND : ST_COLLECT;
					end
				end
				ST_SECOND: begin
					addr_q <= {addr_q[3:1], ~addr_q[0]};
					wr_q <= !is_read_q;
					rd_q <= is_read_q;
					wdata_q <= hold_q;
					state_q <= ST_COLLECT;
				end
				ST_COLLECT: begin
					// read data stands one edge after its strobe, so every read ends in ST_LAST
					if (is_read_q && wide_q) begin
						resp_q <= {8'h00, bus.rdata};
					end
					state_q <= is_read_q ? ST_LAST : ST_IDLE;
					resp_valid_q <= !is_read_q;
					ready_q <= !is_read_q;
				end
				ST_LAST: begin
					resp_q <= wide_q ? {bus.rdata, resp_q[7:0]} : {8'h00, bus.rdata};
					resp_valid_q <= 1'b1;
					ready_q <= 1'b1;
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt service
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			ack_q <= service_pulse && !ack_q;
			irq_q <= bus.irq;
		end
	end

	assign bus.addr = addr_q;
	assign bus.wr_en = wr_q;
	assign bus.rd_en = rd_q;
	assign bus.wdata = wdata_q;
	assign bus.int_ack = ack_q;
	assign cmd_ready = ready_q;
	assign resp_valid = resp_valid_q;
	assign resp_data = resp_q;
	assign irq_level = irq_q;
endmodule

// ---- verilog/timer16_device.sv ----
// Purpose: 16-bit timer/counter with byte-wide register access
// Assumes: cpu on an 8-bit bus, one access per cycle
// Notes: compare double buffering, waveform outputs and capture trigger left out
//
// What this block does
// - wide registers reached as two byte accesses
// - one shared high-byte holding register per timer
// - low byte write loads holding plus low
// - low byte read of counter or capture copies high into holding
// - compare reads bypass the holding register
// - cpu writes high first, reads low first
// - counter high address accesses holding register
// - main code blocks interrupts during wide access; the cpu end passes irq and int_ack in every sequencer state
// - holding register keeps value across low writes
// - three-bit clock select, zero halts counting
// - counter accessible whether or not clocked
// - cpu write beats clear or count
// - per tick clear, increment or decrement
// - four-bit waveform field across controls a, b
// - overflow flag set per mode, requests interrupt
// - bottom at zero, top at sequence maximum
// - counter seen as high and low bytes
// - top fixed value, compare a or capture
// - capture writable only when it is top
`timescale 1ns/100ps
module timer16_device (
	input wire logic clk,
	input wire logic nrst,
	timer_bus_if.dev bus,
	input wire logic ext_clk_pin,
	output logic at_top,
	output logic at_bottom,
	output logic count_down,
	output logic tick_seen
);
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic dir_down_q;
	logic dir_down_d;
	logic [15:0] cmp_q [3];
	logic [15:0] cap_q;
	logic [7:0] temp_q;
	logic [7:0] ctrl_a_q;
	logic [7:0] ctrl_b_q;
	logic ovf_q;
	logic mask_q;
	logic [7:0] rdata_q;
	logic irq_q;
	logic top_q;
	logic bottom_q;
	logic tick_q;
	logic [timer16_pkg::PRESC_W-1:0] presc_q;
	logic [2:0] ext_sync_q;
	logic ext_level_q;
	logic ext_rise;
	logic ext_fall;
	logic tick;
	logic [3:0] wgm;
	logic [2:0] cs;
	logic [15:0] top_val;
	logic dual_slope;
	logic clear_on_top;
	logic ovf_evt;
	logic is_wide;
	logic is_lo;
	logic [2:0] widx;
	logic [15:0] wide_val;
	logic cap_is_top;
	logic cnt_wr;
	assign wgm = {ctrl_b_q[timer16_pkg::CTRL_B_WGM_LSB +: 2],
		ctrl_a_q[timer16_pkg::CTRL_A_WGM_LSB +: 2]};
	assign cs = ctrl_b_q[timer16_pkg::CTRL_B_CS_LSB +: 3];
	assign is_wide = bus.addr < timer16_pkg::ADDR_WIDE_END;
	assign is_lo = ~bus.addr[0];
	assign widx = bus.addr[3:1];
	assign cnt_wr = bus.wr_en && is_wide && is_lo && widx == timer16_pkg::IDX_CNT;
	////////////////////////////////////////////////////////////////////////////////
	// timer tick: prescaler and synchronised external pin
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			presc_q <= '0;
		end else begin
			presc_q <= presc_q + 1'b1;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ext_sync_q <= 3'h0;
			ext_level_q <= 1'b0;
		end else begin
			ext_sync_q <= {ext_sync_q[1:0], ext_clk_pin};
			if (ext_sync_q[1] == ext_sync_q[2]) begin
				ext_level_q <= ext_sync_q[2];
			end
		end
	end
	assign ext_rise = ext_sync_q[1] && ext_sync_q[2] && !ext_level_q;
	assign ext_fall = !ext_sync_q[1] && !ext_sync_q[2] && ext_level_q;
	always_comb begin
		case (cs)
			timer16_pkg::CS_STOP: tick = 1'b0;
			timer16_pkg::CS_DIV1: tick = 1'b1;
			timer16_pkg::CS_DIV8: tick = &presc_q[2:0];
			timer16_pkg::CS_DIV64: tick = &presc_q[5:0];
			timer16_pkg::CS_DIV256: tick = &presc_q[7:0];
			timer16_pkg::CS_DIV1024: tick = &presc_q[9:0];
			timer16_pkg::CS_EXT_FALL: tick = ext_fall;
			timer16_pkg::CS_EXT_RISE: tick = ext_rise;
			default: tick = 1'b0;
		endcase
	end
	////////////////////////////////////////////////////////////////////////////////
	// mode decode
	always_comb begin
		case (wgm)
			4'h1, 4'h5: top_val = timer16_pkg::TOP_FIX8;
			4'h2, 4'h6: top_val = timer16_pkg::TOP_FIX9;
			4'h3, 4'h7: top_val = timer16_pkg::TOP_FIX10;
			4'h4, 4'h9, 4'hb, 4'hf: top_val = cmp_q[0];
			4'h8, 4'ha, 4'hc, 4'he: top_val = cap_q;
			default: top_val = timer16_pkg::COUNT_MAX;
		endcase
	end
	assign dual_slope = wgm inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb};
	assign clear_on_top = wgm inside {4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'he, 4'hf};
	assign cap_is_top = wgm inside {4'h8, 4'ha, 4'hc, 4'he};
	assign ovf_evt = tick && (dual_slope ? cnt_q == 16'h0000
		: wgm inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf} ? cnt_q == top_val
		: cnt_q == timer16_pkg::COUNT_MAX);
	////////////////////////////////////////////////////////////////////////////////
	// counter core
	always_comb begin
		cnt_d = cnt_q;
		dir_down_d = dir_down_q;
		if (tick) begin
			if (dual_slope) begin
				if (!dir_down_q && cnt_q >= top_val) begin
					dir_down_d = 1'b1;
					cnt_d = cnt_q - 1'b1;
				end else if (dir_down_q && cnt_q == 16'h0000) begin
					dir_down_d = 1'b0;
					cnt_d = cnt_q + 1'b1;
				end else if (dir_down_q) begin
					cnt_d = cnt_q - 1'b1;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end else if (clear_on_top && cnt_q == top_val) begin
				cnt_d = 16'h0000;
			end else begin
				dir_down_d = 1'b0;
				cnt_d = cnt_q + 1'b1;
			end
		end
		if (cnt_wr) begin
			cnt_d = {temp_q, bus.wdata};
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= timer16_pkg::WIDE_RESET;
			dir_down_q <= 1'b0;
			top_q <= 1'b0;
			bottom_q <= 1'b1;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			dir_down_q <= dir_down_d;
			top_q <= cnt_d == top_val;
			bottom_q <= cnt_d == 16'h0000;
			tick_q <= tick;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// bus writes: holding, compare, capture, control
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			temp_q <= 8'h00;
		end else if (bus.wr_en && is_wide && !is_lo) begin
			temp_q <= bus.wdata;
		end else if (bus.rd_en && is_wide && is_lo && (widx == timer16_pkg::IDX_CNT
			|| widx == timer16_pkg::IDX_CAP)) begin
			temp_q <= wide_val[15:8];
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cmp_q <= '{timer16_pkg::WIDE_RESET, timer16_pkg::WIDE_RESET, timer16_pkg::WIDE_RESET};
			cap_q <= timer16_pkg::WIDE_RESET;
		end else if (bus.wr_en && is_wide && is_lo) begin
			if (widx == timer16_pkg::IDX_CAP) begin
				if (cap_is_top) begin
					cap_q <= {temp_q, bus.wdata};
				end
			end else if (widx != timer16_pkg::IDX_CNT) begin
				cmp_q[widx[1:0] - 2'h1] <= {temp_q, bus.wdata};
			end
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_a_q <= timer16_pkg::CTRL_RESET;
			ctrl_b_q <= timer16_pkg::CTRL_RESET;
			mask_q <= 1'b0;
		end else if (bus.wr_en) begin
			if (bus.addr == timer16_pkg::ADDR_CTRL_A) begin
				ctrl_a_q <= bus.wdata;
			end
			if (bus.addr == timer16_pkg::ADDR_CTRL_B) begin
				ctrl_b_q <= bus.wdata;
			end
			if (bus.addr == timer16_pkg::ADDR_MASK) begin
				mask_q <= bus.wdata[timer16_pkg::FLAG_OVF_BIT];
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// overflow flag and interrupt request
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ovf_q <= 1'b0;
		end else if (ovf_evt) begin
			ovf_q <= 1'b1;
		end else if (bus.int_ack || (bus.wr_en && bus.addr == timer16_pkg::ADDR_FLAGS
			&& bus.wdata[timer16_pkg::FLAG_OVF_BIT])) begin
			ovf_q <= 1'b0;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (ovf_q || ovf_evt) && mask_q && !bus.int_ack;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// bus reads
	assign wide_val = widx == timer16_pkg::IDX_CNT ? cnt_q
		: widx == timer16_pkg::IDX_CAP ? cap_q : cmp_q[widx[1:0] - 2'h1];
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 8'h00;
		end else if (bus.rd_en) begin
			if (is_wide && is_lo) begin
				rdata_q <= wide_val[7:0];
			end else if (is_wide && (widx == timer16_pkg::IDX_CNT
				|| widx == timer16_pkg::IDX_CAP)) begin
				rdata_q <= temp_q;
			end else if (is_wide) begin
				rdata_q <= wide_val[15:8];
			end else if (bus.addr == timer16_pkg::ADDR_CTRL_A) begin
				rdata_q <= ctrl_a_q;
			end else if (bus.addr == timer16_pkg::ADDR_CTRL_B) begin
				rdata_q <= ctrl_b_q;
			end else if (bus.addr == timer16_pkg::ADDR_FLAGS) begin
				rdata_q <= {7'h00, ovf_q};
			end else if (bus.addr == timer16_pkg::ADDR_MASK) begin
				rdata_q <= {7'h00, mask_q};
			end else begin
				rdata_q <= 8'h00;
			end
		end
	end
	assign bus.rdata = rdata_q;
	assign bus.irq = irq_q;
	assign at_top = top_q;
	assign at_bottom = bottom_q;
	assign count_down = dir_down_q;
	assign tick_seen = tick_q;
endmodule
